// *** hw/ccx_exec.sv ***
// Execution unit for call, clear, watchdog-clear and complement instructions
//
// Operation
// - Call pushes program counter plus one.
// - Call then loads program counter with target.
// - Call takes two cycles, flags untouched.
// - Byte clear writes zero, flags untouched.
// - Bit clear zeroes only selected bit.
// - Watchdog clear resets counter, timeout, powerdown.
// - Pre-clear variants act only when alternated.
// - Repeated same pre-clear variant does nothing.
// - Complement inverts every bit of byte.
`timescale 1ns/100ps

module ccx_exec
  import ccx_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  input  wire logic              req_valid_in,
  input  wire ccx_req_s          req_in,
  input  wire logic [PC_W-1:0]   pc_in,
  input  wire logic [DATA_W-1:0] mem_rdata_in,
  input  wire logic              timeout_set_in,
  input  wire logic              powerdown_set_in,
  output logic                   req_ready_out,
  output logic                   stack_push_out,
  output logic [PC_W-1:0]        stack_data_out,
  output logic                   pc_load_out,
  output logic [PC_W-1:0]        pc_value_out,
  output logic                   mem_we_out,
  output ccx_mem_wr_s            mem_wr_out,
  output logic                   watchdog_counter_clear_out,
  output logic                   timeout_flag_out,
  output logic                   powerdown_flag_out,
  output logic                   zero_flag_out
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic {CCX_ST_IDLE, CCX_ST_CALL2} ccx_state_e;

  ccx_state_e        state;
  ccx_state_e        next_state;
  logic [PC_W-1:0]   call_target;

  wire accept      = req_valid_in && req_ready_out;
  wire is_call     = accept && req_in.op == CCX_OP_CALL;
  wire is_clr_byte = accept && req_in.op == CCX_OP_CLR_BYTE;
  wire is_clr_bit  = accept && req_in.op == CCX_OP_CLR_BIT;
  wire is_wdt_clr  = accept && req_in.op == CCX_OP_WDT_CLEAR;
  wire is_pre1     = accept && req_in.op == CCX_OP_PRECLEAR_FIRST;
  wire is_pre2     = accept && req_in.op == CCX_OP_PRECLEAR_SECOND;
  wire is_compl    = accept && req_in.op == CCX_OP_COMPLEMENT;

  // Second cycle of a call blocks the pipeline for the extra operation
  assign req_ready_out = (state == CCX_ST_IDLE);
  assign next_state    = is_call ? CCX_ST_CALL2 : CCX_ST_IDLE;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state       <= CCX_ST_IDLE;
      call_target <= PC_RESET;
    end else begin
      state <= next_state;
      if (is_call) begin
        call_target <= req_in.target;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack push and program counter load
  // ----------------------------------------------------------------
  wire [PC_W-1:0] next_return = pc_in + PC_STEP;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_push_out <= 1'b0;
      stack_data_out <= PC_RESET;
      pc_load_out    <= 1'b0;
      pc_value_out   <= PC_RESET;
    end else begin
      stack_push_out <= is_call;
      if (is_call) begin
        stack_data_out <= next_return;
      end
      // Load lands after the push so the return address is saved first
      pc_load_out <= (state == CCX_ST_CALL2);
      if (state == CCX_ST_CALL2) begin
        pc_value_out <= call_target;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory write-back
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] next_wdata;

  generate
    for (genvar b = 0; b < DATA_W; b++) begin : g_mask
      assign bit_mask[b] = (req_in.bit_sel != BIT_W'(b));
    end
  endgenerate

  wire [DATA_W-1:0] compl_result = ~mem_rdata_in;
  wire              mem_op       = is_clr_byte || is_clr_bit || is_compl;

  assign next_wdata = is_clr_byte ? BYTE_CLEARED :
                      is_clr_bit  ? (mem_rdata_in & bit_mask) :
                      compl_result;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_we_out      <= 1'b0;
      mem_wr_out.addr <= ADDR_RESET;
      mem_wr_out.data <= BYTE_CLEARED;
    end else begin
      mem_we_out <= mem_op;
      if (mem_op) begin
        mem_wr_out.addr <= req_in.mem_addr;
        mem_wr_out.data <= next_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog clear and status flags
  // ----------------------------------------------------------------
  logic     pre_clear;
  ccx_arm_e pre_armed;

  ccx_wdt_preclear u_preclear (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .first_in   (is_pre1),
    .second_in  (is_pre2),
    .clear_out  (pre_clear),
    .armed_out  (pre_armed)
  );

  wire wdt_clr = is_wdt_clr || pre_clear;

  // A set arriving with the clear wins, so a fresh time-out is never lost
  wire next_timeout   = timeout_set_in   || (timeout_flag_out && !wdt_clr);
  wire next_powerdown = powerdown_set_in || (powerdown_flag_out && !wdt_clr);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      watchdog_counter_clear_out <= 1'b0;
      timeout_flag_out           <= 1'b0;
      powerdown_flag_out         <= 1'b0;
      zero_flag_out              <= 1'b0;
    end else begin
      watchdog_counter_clear_out <= wdt_clr;
      timeout_flag_out           <= next_timeout;
      powerdown_flag_out         <= next_powerdown;
      // Only the complement touches the zero flag here
      if (is_compl) begin
        zero_flag_out <= (compl_result == BYTE_CLEARED);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_call_push(logic [PC_W-1:0] ret);
    stack_push_out && stack_data_out == ret && !pc_load_out && !req_ready_out;
  endsequence

  sequence s_call_load(logic [PC_W-1:0] tgt);
    pc_load_out && pc_value_out == tgt && !stack_push_out && req_ready_out;
  endsequence

  property p_call(logic [PC_W-1:0] ret, logic [PC_W-1:0] tgt);
    is_call |=> s_call_push(ret) ##1 s_call_load(tgt);
  endproperty

  // Arguments are read where they are used, so both look back to the taking edge
  chk_call_push_load: assert property (p_call($past(pc_in) + PC_STEP, $past(req_in.target, 2)))
    else $error("call push or load wrong");

  chk_call_flags_kept: assert property (is_call |=> $stable(zero_flag_out)[*2])
    else $error("call changed zero flag");

  chk_clr_byte_zero: assert property (is_clr_byte |=> mem_we_out && mem_wr_out.data == BYTE_CLEARED
      && mem_wr_out.addr == $past(req_in.mem_addr) && $stable(zero_flag_out))
    else $error("byte clear wrong");

  chk_clr_bit_only: assert property (is_clr_bit |=> mem_we_out
      && mem_wr_out.data == ($past(mem_rdata_in) & ~(8'h01 << $past(req_in.bit_sel))))
    else $error("bit clear wrong");

  chk_wdt_clear_all: assert property (is_wdt_clr && !timeout_set_in && !powerdown_set_in
      |=> watchdog_counter_clear_out && !timeout_flag_out && !powerdown_flag_out)
    else $error("watchdog clear incomplete");

  chk_preclear_alternate: assert property ((is_pre1 && pre_armed == CCX_ARM_SECOND
      || is_pre2 && pre_armed == CCX_ARM_FIRST) && !timeout_set_in && !powerdown_set_in
      |=> watchdog_counter_clear_out && !timeout_flag_out && !powerdown_flag_out)
    else $error("alternating pre-clear ignored");

  chk_preclear_repeat: assert property ((is_pre1 && pre_armed != CCX_ARM_SECOND
      || is_pre2 && pre_armed != CCX_ARM_FIRST) && !is_wdt_clr
      |=> !watchdog_counter_clear_out)
    else $error("repeated pre-clear acted");

  chk_compl_invert: assert property (is_compl |=> mem_we_out
      && mem_wr_out.data == ~$past(mem_rdata_in) && mem_wr_out.addr == $past(req_in.mem_addr))
    else $error("complement wrong");

  chk_compl_zero: assert property (is_compl |=> zero_flag_out == ($past(mem_rdata_in) == 8'hff))
    else $error("complement zero flag wrong");

endmodule

// *** hw/ccx_pkg.sv ***
// Package: shared types and constants for the call/clear/complement execution block
package ccx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W   = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BIT_W  = 3;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_STEP      = 11'h001;
  localparam logic [DATA_W-1:0] BYTE_CLEARED = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET     = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCX_OP_NOP,
    CCX_OP_CALL,
    CCX_OP_CLR_BYTE,
    CCX_OP_CLR_BIT,
    CCX_OP_WDT_CLEAR,
    CCX_OP_PRECLEAR_FIRST,
    CCX_OP_PRECLEAR_SECOND,
    CCX_OP_COMPLEMENT
  } ccx_op_e;

  typedef enum logic [1:0] {
    CCX_ARM_NONE,
    CCX_ARM_FIRST,
    CCX_ARM_SECOND
  } ccx_arm_e;

  typedef struct packed {
    ccx_op_e           op;
    logic [PC_W-1:0]   target;
    logic [ADDR_W-1:0] mem_addr;
    logic [BIT_W-1:0]  bit_sel;
  } ccx_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ccx_mem_wr_s;

endpackage

// *** hw/ccx_wdt_preclear.sv ***
// Tracker that lets the two pre-clear watchdog instructions act only in alternation
`timescale 1ns/100ps

module ccx_wdt_preclear
  import ccx_pkg::*;
(
  input  wire logic     clk_sys_in,
  input  wire logic     reset_n_in,
  input  wire logic     first_in,
  input  wire logic     second_in,
  output logic          clear_out,
  output ccx_arm_e      armed_out
);

  ccx_arm_e armed;
  ccx_arm_e next_armed;

  // A variant clears only when the other one is armed; repeats just re-arm
  assign clear_out = (first_in && armed == CCX_ARM_SECOND) ||
                     (second_in && armed == CCX_ARM_FIRST);

  // After a clear the pair starts over, so the next clear needs a fresh pair
  assign next_armed = clear_out ? CCX_ARM_NONE :
                      first_in  ? CCX_ARM_FIRST :
                      second_in ? CCX_ARM_SECOND : armed;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      armed <= CCX_ARM_NONE;
    end else begin
      armed <= next_armed;
    end
  end

  assign armed_out = armed;

endmodule

// *** tb/ccx_mem_model.sv ***
// Data memory partner model that answers reads at once and takes write-backs
`timescale 1ns/100ps

module ccx_mem_model
  import ccx_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              we_in,
  input  wire ccx_mem_wr_s       wr_in,
  output logic [DATA_W-1:0]      rdata_out
);
  logic [DATA_W-1:0] mem [256];

  // Read is combinational so the block sees the byte in its accept cycle
  assign rdata_out = mem[addr_in];

  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the call, clear and complement execution block
`timescale 1ns/100ps

module testbench;
  import ccx_pkg::*;
  typedef struct {ccx_op_e op; logic [7:0] a; logic [2:0] b; logic [7:0] d; logic [7:0] e; logic z;} ccx_row_s;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0, timeout_set_in = 1'b0, powerdown_set_in = 1'b0;
  ccx_req_s req_in = '0;
  logic [PC_W-1:0] pc_in = '0, stack_data_out, pc_value_out;
  logic [DATA_W-1:0] mem_rdata_in;
  logic req_ready_out, stack_push_out, pc_load_out, mem_we_out, watchdog_counter_clear_out;
  logic timeout_flag_out, powerdown_flag_out, zero_flag_out;
  ccx_mem_wr_s mem_wr_out;
  int err_count = 0, n_tests = 0, cyc = 0;
  ccx_row_s rows[$];

  always #4 clk_sys_in = ~clk_sys_in;

  ccx_exec dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .pc_in(pc_in), .mem_rdata_in(mem_rdata_in), .timeout_set_in(timeout_set_in), .powerdown_set_in(powerdown_set_in),
    .req_ready_out(req_ready_out), .stack_push_out(stack_push_out), .stack_data_out(stack_data_out),
    .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .mem_we_out(mem_we_out), .mem_wr_out(mem_wr_out),
    .watchdog_counter_clear_out(watchdog_counter_clear_out), .timeout_flag_out(timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out), .zero_flag_out(zero_flag_out));
  ccx_mem_model mem_u (.clk_sys_in(clk_sys_in), .addr_in(req_in.mem_addr), .we_in(mem_we_out),
    .wr_in(mem_wr_out), .rdata_out(mem_rdata_in));

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin err_count++; $display("BAD %s expected %b seen %b", n, e, g); end
  endtask
  task automatic chk_val(input string n, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin err_count++; $display("BAD %s expected %h seen %h", n, e, g); end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Returns at the falling edge of the cycle after the taking edge
  task automatic issue(input ccx_op_e op, input logic [7:0] a, input logic [2:0] b, input logic [10:0] t);
    @(negedge clk_sys_in);
    req_in = {op, t, a, b};
    req_valid_in = 1'b1;
    // Ready only moves on a rising edge, so it is settled here and holds to the next one
    while (req_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
  endtask
  task automatic set_flags();
    @(negedge clk_sys_in);
    timeout_set_in = 1'b1;
    powerdown_set_in = 1'b1;
    @(negedge clk_sys_in);
    timeout_set_in = 1'b0;
    powerdown_set_in = 1'b0;
  endtask
  task automatic wd(input ccx_op_e op, input logic e);
    set_flags();
    issue(op, 8'h00, 3'h0, 11'h000);
    chk_bit("wdt_clear", e, watchdog_counter_clear_out);
    chk_bit("timeout", !e, timeout_flag_out);
    chk_bit("powerdown", !e, powerdown_flag_out);
  endtask

  // Hang guard: the whole sequence needs about a hundred cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin err_count++; give_verdict(); end
  end

  initial begin
    rows.push_back('{CCX_OP_CLR_BYTE, 8'h10, 3'h0, 8'hff, 8'h00, 1'b0});
    for (int i = 0; i < 8; i++) rows.push_back('{CCX_OP_CLR_BIT, 8'h20 + i[7:0], i[2:0], 8'hff, ~(8'h01 << i), 1'b0});
    rows.push_back('{CCX_OP_COMPLEMENT, 8'h00, 3'h0, 8'h00, 8'hff, 1'b0});
    rows.push_back('{CCX_OP_COMPLEMENT, 8'h40, 3'h0, 8'ha5, 8'h5a, 1'b0});
    rows.push_back('{CCX_OP_COMPLEMENT, 8'hff, 3'h0, 8'hff, 8'h00, 1'b1});
    rows.push_back('{CCX_OP_CLR_BYTE, 8'h11, 3'h0, 8'h5c, 8'h00, 1'b1});
    rows.push_back('{CCX_OP_CLR_BIT, 8'h30, 3'h7, 8'h80, 8'h00, 1'b1});
    repeat (12) @(negedge clk_sys_in);
    chk_bit("ready", 1'b1, req_ready_out);
    chk_bit("flags", 1'b0, timeout_flag_out | powerdown_flag_out | zero_flag_out | mem_we_out | stack_push_out);
    reset_n_in = 1'b1;
    foreach (rows[i]) begin
      mem_u.mem[rows[i].a] = rows[i].d;
      issue(rows[i].op, rows[i].a, rows[i].b, 11'h000);
      chk_bit("mem_we", 1'b1, mem_we_out);
      chk_val("mem_addr", {3'h0, rows[i].a}, {3'h0, mem_wr_out.addr});
      chk_val("mem_data", {3'h0, rows[i].e}, {3'h0, mem_wr_out.data});
      chk_bit("zero", rows[i].z, zero_flag_out);
      @(negedge clk_sys_in);
      chk_val("stored", {3'h0, rows[i].e}, {3'h0, mem_u.mem[rows[i].a]});
    end
    // Call at the top of a page so the return address carries
    pc_in = 11'h3ff;
    issue(CCX_OP_CALL, 8'h00, 3'h0, 11'h555);
    chk_bit("push", 1'b1, stack_push_out);
    chk_val("ret_addr", 11'h400, stack_data_out);
    chk_bit("ready_c1", 1'b0, req_ready_out);
    chk_bit("load_c1", 1'b0, pc_load_out);
    @(negedge clk_sys_in);
    chk_bit("load", 1'b1, pc_load_out);
    chk_val("target", 11'h555, pc_value_out);
    chk_bit("push_c2", 1'b0, stack_push_out);
    chk_bit("zero_kept", 1'b1, zero_flag_out);
    wd(CCX_OP_WDT_CLEAR, 1'b1);
    wd(CCX_OP_PRECLEAR_FIRST, 1'b0);
    wd(CCX_OP_PRECLEAR_FIRST, 1'b0);
    wd(CCX_OP_PRECLEAR_SECOND, 1'b1);
    wd(CCX_OP_PRECLEAR_SECOND, 1'b0);
    wd(CCX_OP_PRECLEAR_SECOND, 1'b0);
    issue(CCX_OP_NOP, 8'h00, 3'h0, 11'h000);
    wd(CCX_OP_PRECLEAR_FIRST, 1'b1);
    // Reset in mid-run drops the flags
    set_flags();
    reset_n_in = 1'b0;
    @(negedge clk_sys_in);
    chk_bit("rst_flags", 1'b0, timeout_flag_out | powerdown_flag_out);
    chk_bit("rst_ready", 1'b1, req_ready_out);
    reset_n_in = 1'b1;
    give_verdict();
  end
endmodule
